// [hw/mrz_field_decode.v]
// Purpose: Turns mode register zero codes into clock counts and flags.
// Assumes: Combinational; the caller registers its outputs.
// Notes:   Reserved write and CAS codes give zero counts; these and burst length code 3 raise a reserved flag.
`include "mrzero_consts.vh"

module mrz_field_decode (
    input  wire [`MRZ_WORD_W-1:0] word_in,
    output reg  [5:0]             wr_clk_out,
    output reg  [4:0]             rtp_clk_out,
    output reg  [5:0]             cas_clk_out,
    output reg                    reserved_out
);
    wire [3:0] wr_code;
    wire [4:0] cl_code;

    assign wr_code = {word_in[`MRZ_BIT_WR_HI], word_in[`MRZ_WR_LO_HI:`MRZ_WR_LO_LO]};
    assign cl_code = {word_in[`MRZ_BIT_CL_HI], word_in[`MRZ_CL_MID_HI:`MRZ_CL_MID_LO],
                      word_in[`MRZ_BIT_CL_LO]};

    always @* begin
        case (wr_code)
            4'h0: wr_clk_out = 6'd10;
            4'h1: wr_clk_out = 6'd12;
            4'h2: wr_clk_out = 6'd14;
            4'h3: wr_clk_out = 6'd16;
            4'h4: wr_clk_out = 6'd18;
            4'h5: wr_clk_out = 6'd20;
            4'h6: wr_clk_out = 6'd24;
            4'h7: wr_clk_out = 6'd22;
            4'h8: wr_clk_out = 6'd26;
            default: wr_clk_out = 6'd0;
        endcase
        rtp_clk_out = wr_clk_out[5:1];
    end

    always @* begin
        case (cl_code)
            5'h08: cas_clk_out = 6'd18;
            5'h09: cas_clk_out = 6'd20;
            5'h0a: cas_clk_out = 6'd22;
            5'h0b: cas_clk_out = 6'd24;
            5'h0c: cas_clk_out = 6'd23;
            5'h0d: cas_clk_out = 6'd17;
            5'h0e: cas_clk_out = 6'd19;
            5'h0f: cas_clk_out = 6'd21;
            default: begin
                if (cl_code < 5'h08) begin
                    cas_clk_out = {3'b000, cl_code[2:0]} + 6'd9;
                end else if (cl_code <= `MRZ_CL_MAX_CODE) begin
                    cas_clk_out = {3'b000, cl_code[2:0]} + 6'd25;
                end else begin
                    cas_clk_out = 6'd0;
                end
            end
        endcase
    end

    always @* begin
        reserved_out = (wr_code > `MRZ_WR_MAX_CODE) || (cl_code > `MRZ_CL_MAX_CODE)
                    || (word_in[`MRZ_BL_HI:`MRZ_BL_LO] == `MRZ_BL_RESERVED);
    end
endmodule // mrz_field_decode

// [hw/mrz_mode_reg.v]
// Purpose: Mode register set decoder holding mode register zero.
// Assumes: Command and address pins are synchronous to clk_sys_in.
// Notes:   Writes to other mode registers are flagged but not stored here.
`include "mrzero_consts.vh"

module mrz_mode_reg (
    input  wire        clk_sys_in,
    input  wire        reset_n_in,
    input  wire        cs_n_in,
    input  wire        ras_n_in,
    input  wire        cas_n_in,
    input  wire        we_n_in,
    input  wire [1:0]  bg_in,
    input  wire [1:0]  ba_in,
    input  wire [17:0] addr_in,
    output wire [21:0] mode_register_zero_out,
    output reg  [2:0]  mrs_target_out,
    output reg         mrs_other_out,
    output reg         mrs_dnu_out,
    output reg  [5:0]  wr_clk_out,
    output reg  [4:0]  rtp_clk_out,
    output reg  [5:0]  cas_clk_out,
    output reg         burst_interleave_out,
    output reg  [1:0]  burst_len_out,
    output reg         vendor_test_mode_out,
    output reg         reserved_set_out,
    output reg         dll_reset_pulse_out,
    output wire        dll_reset_busy_out
);
    reg  [21:0] mode_register_zero_q;
    reg  [7:0]  dll_cnt_q;
    wire        mrs_cmd;
    wire [21:0] mrs_word;
    wire        mrs_is_zero;
    wire [5:0]  dec_wr;
    wire [4:0]  dec_rtp;
    wire [5:0]  dec_cas;
    wire        dec_res;

    function [2:0] mrz_target;
        input [21:0] w;
        begin
            mrz_target = w[`MRZ_SEL_HI:`MRZ_SEL_LO];
        end
    endfunction

    assign mrs_cmd = ~cs_n_in & ~ras_n_in & ~cas_n_in & ~we_n_in;

    assign mrs_word = {bg_in, ba_in, addr_in[17], 3'b000, addr_in[13:0]};

    assign mrs_is_zero = mrs_cmd && (mrz_target(mrs_word) == `MRZ_SEL_MR0);

    assign mode_register_zero_out = mode_register_zero_q;
    assign dll_reset_busy_out     = (dll_cnt_q != 8'h00);

    mrz_field_decode u_dec (
        .word_in      (mode_register_zero_q),
        .wr_clk_out   (dec_wr),
        .rtp_clk_out  (dec_rtp),
        .cas_clk_out  (dec_cas),
        .reserved_out (dec_res)
    );

    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            mode_register_zero_q <= `MRZ_RESET_WORD;
            dll_cnt_q            <= 8'h00;
            dll_reset_pulse_out  <= 1'b0;
            mrs_target_out       <= 3'h0;
            mrs_other_out        <= 1'b0;
            mrs_dnu_out          <= 1'b0;
        end else begin
            dll_reset_pulse_out <= 1'b0;
            mrs_other_out       <= mrs_cmd && !mrs_is_zero;
            mrs_dnu_out         <= mrs_cmd && (mrz_target(mrs_word) == `MRZ_SEL_DNU);
            if (mrs_cmd) begin
                mrs_target_out <= mrz_target(mrs_word);
            end
            if (mrs_is_zero) begin
                mode_register_zero_q <= mrs_word;
                if (mrs_word[`MRZ_BIT_DLL_RST]) begin
                    dll_cnt_q           <= `MRZ_DLL_RST_CYC;
                    dll_reset_pulse_out <= 1'b1;
                end
            end else if (dll_cnt_q != 8'h00) begin
                dll_cnt_q <= dll_cnt_q - 8'h01;
                if (dll_cnt_q == 8'h01) begin
                    mode_register_zero_q[`MRZ_BIT_DLL_RST] <= 1'b0;
                end
            end
        end
    end

    // Decoded settings are applied the cycle after the register updates.
    always @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            wr_clk_out           <= 6'd0;
            rtp_clk_out          <= 5'd0;
            cas_clk_out          <= 6'd0;
            burst_interleave_out <= 1'b0;
            burst_len_out        <= 2'b00;
            vendor_test_mode_out <= 1'b0;
            reserved_set_out     <= 1'b0;
        end else begin
            wr_clk_out           <= dec_wr;
            rtp_clk_out          <= dec_rtp;
            cas_clk_out          <= dec_cas;
            burst_interleave_out <= mode_register_zero_q[`MRZ_BIT_BT];
            burst_len_out        <= mode_register_zero_q[`MRZ_BL_HI:`MRZ_BL_LO];
            vendor_test_mode_out <= mode_register_zero_q[`MRZ_BIT_TEST];
            reserved_set_out     <= dec_res | mode_register_zero_q[`MRZ_BIT_RFU_HI]
                                  | mode_register_zero_q[`MRZ_BIT_RFU_LO];
        end
    end
endmodule // mrz_mode_reg

// [hw/mrzero_consts.vh]
// Purpose: Constants for the mode-register-set decoder and mode register zero.
// Assumes: Plain Verilog-2005, included by bare name.
// Notes:   Field positions are bit numbers of the 22-bit mode register word.
`ifndef MRZERO_CONSTS_VH
`define MRZERO_CONSTS_VH

`define MRZ_WORD_W        22
`define MRZ_BIT_RFU_HI    21
`define MRZ_SEL_HI        20
`define MRZ_SEL_LO        18
`define MRZ_BIT_RFU_LO    17
`define MRZ_BIT_WR_HI     13
`define MRZ_BIT_CL_HI     12
`define MRZ_WR_LO_HI      11
`define MRZ_WR_LO_LO      9
`define MRZ_BIT_DLL_RST   8
`define MRZ_BIT_TEST      7
`define MRZ_CL_MID_HI     6
`define MRZ_CL_MID_LO     4
`define MRZ_BIT_BT        3
`define MRZ_BIT_CL_LO     2
`define MRZ_BL_HI         1
`define MRZ_BL_LO         0

`define MRZ_SEL_MR0       3'h0
`define MRZ_SEL_DNU       3'h7
`define MRZ_WR_MAX_CODE   4'h8
`define MRZ_CL_MAX_CODE   5'h17
`define MRZ_BL_RESERVED   2'h3

`define MRZ_RESET_WORD    22'h00_0000
`define MRZ_DLL_RST_CYC   8'h04

`endif

// [verif/dram_mode_register_set_mr0_tb_top.sv]
// Purpose: Self-checking bench for the mode register block.
// Assumes: Commands come from the controller model.
// Notes:   Expected fields come from a table model.
module dram_mode_register_set_mr0_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 0, reset_n_in = 0;
    logic [21:0] mr = 0, w;
    wire cs_n, ras_n, cas_n, we_n, oth, dnu, itl, vtm, rsv, pls, bsy;
    wire [1:0] bg, ba, bl;
    wire [17:0] addr;
    wire [21:0] mrz;
    wire [2:0] tgt;
    wire [5:0] wr, cas;
    wire [4:0] rtp;
    int n_fail = 0, checked = 0, cl, wc;
    initial forever #10 clk_sys_in = ~clk_sys_in;
    mrz_ctl_model i_ctl (.clk_sys_in, .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n),
        .we_n_out(we_n), .bg_out(bg), .ba_out(ba), .addr_out(addr));
    mrz_mode_reg i_dut (.clk_sys_in, .reset_n_in, .cs_n_in(cs_n), .ras_n_in(ras_n),
        .cas_n_in(cas_n), .we_n_in(we_n), .bg_in(bg), .ba_in(ba), .addr_in(addr),
        .mode_register_zero_out(mrz), .mrs_target_out(tgt), .mrs_other_out(oth),
        .mrs_dnu_out(dnu), .wr_clk_out(wr), .rtp_clk_out(rtp), .cas_clk_out(cas),
        .burst_interleave_out(itl), .burst_len_out(bl), .vendor_test_mode_out(vtm),
        .reserved_set_out(rsv), .dll_reset_pulse_out(pls), .dll_reset_busy_out(bsy));
    task automatic give_verdict;
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge clk_sys_in);
        #1;
    endtask
    function automatic int cas_of(input int c);
        int t[8] = '{18, 20, 22, 24, 23, 17, 19, 21};
        return (c > 23) ? 0 : (c < 8 || c > 15) ? 9 + c : t[c - 8];
    endfunction
    function automatic int wr_of(input int c);
        return (c < 6) ? 10 + 2 * c : (c == 6) ? 24 : (c == 7) ? 22 : (c == 8) ? 26 : 0;
    endfunction
    initial begin
        void'($urandom(32'h908e));
        repeat (12) @(negedge clk_sys_in);
        reset_n_in = 1;
        step;
        chk({mrz, cas}, {22'h0, 6'(cas_of(0))});
        for (int i = 0; i < 44; i++) begin
            w = 22'($urandom);
            w[20:18] = (i >= 32 && i < 40) ? 3'(i - 32) : 3'h0;
            if (i < 40) begin
                {w[12], w[6:4], w[2]} = 5'(i);
                {w[13], w[11:9]} = 4'(i);
            end
            if ({w[12], w[6:4], w[2]} inside {5'h10, 5'h12}) w[2] = 1'b1;
            // Reserved and test bits low except in the last misuse writes.
            {w[21], w[17], w[7]} = (i < 40) ? 3'h0 : 3'(i - 39);
            w[16:14] = 3'h0;
            w[8] = (i == 5);
            i_ctl.mrs(w);
            if (w[20:18] == 3'h0) mr = w;
            chk(mrz, mr);
            chk(tgt, w[20:18]);
            chk({oth, dnu, pls}, {|w[20:18], &w[20:18], ~|w[20:18] & w[8]});
            chk(bsy, w[8]);
            step;
            cl = cas_of({mr[12], mr[6:4], mr[2]});
            wc = wr_of({mr[13], mr[11:9]});
            chk({cas, wr, rtp}, {cl[5:0], wc[5:0], wc[5:1]});
            chk({itl, bl, vtm}, {mr[3], mr[1:0], mr[7]});
            chk(rsv, mr[21] | mr[17] | &mr[1:0] | cl == 0 | wc == 0);
            if (w[8]) begin
                repeat (3) step;
                mr[8] = 1'b0;
                chk({mrz[8], bsy}, 0);
            end
        end
        // Mid-run reset clears the stored word and the DLL count.
        @(negedge clk_sys_in);
        reset_n_in = 0;
        repeat (2) @(negedge clk_sys_in);
        reset_n_in = 1;
        step;
        chk({mrz, cas, bsy}, {22'h0, 6'(cas_of(0)), 1'b0});
        give_verdict;
    end
    initial begin
        #100000 n_fail++;
        give_verdict;
    end
endmodule // dram_mode_register_set_mr0_tb_top

// [verif/mrz_chk.sv]
// Purpose: Port timing checks for the mode register block.
// Assumes: Bound to mrz_mode_reg.
// Notes:   Loads and pulses land one cycle after the command.
module mrz_chk (
    input wire        clk_sys_in,
    input wire        reset_n_in,
    input wire        cs_n_in,
    input wire        ras_n_in,
    input wire        cas_n_in,
    input wire        we_n_in,
    input wire [1:0]  bg_in,
    input wire [1:0]  ba_in,
    input wire [17:0] addr_in,
    input wire [21:0] mode_register_zero_out,
    input wire [2:0]  mrs_target_out,
    input wire        mrs_other_out,
    input wire        reserved_set_out,
    input wire        dll_reset_pulse_out,
    input wire        dll_reset_busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    wire        mrs = !(cs_n_in | ras_n_in | cas_n_in | we_n_in);
    wire [2:0]  sel = {bg_in[0], ba_in};
    wire [21:0] m   = mode_register_zero_out;
    a_word_load: assert property ($past(mrs && sel == 3'h0) |->
        m == $past({bg_in, ba_in, addr_in[17], 3'h0, addr_in[13:0]})) else $error("word");
    a_target_pick: assert property ($past(mrs) |-> mrs_target_out == $past(sel))
        else $error("target");
    a_other_pulse: assert property (mrs_other_out == $past(mrs && sel != 3'h0))
        else $error("other");
    a_dll_pulse: assert property (dll_reset_pulse_out == $past(mrs && !sel && addr_in[8]))
        else $error("dll pulse");
    a_busy_start: assert property ($past(mrs && !sel && addr_in[8]) |-> dll_reset_busy_out)
        else $error("busy");
    a_dll_clear: assert property (dll_reset_pulse_out |-> ##[4:8] !dll_reset_busy_out && !m[8])
        else $error("dll clear");
    a_rsv_flag: assert property ($past(m[21] | m[17] | &m[1:0]) |-> reserved_set_out)
        else $error("reserved");
    a_unused_zero: assert property (m[16:14] == 3'h0) else $error("unused bits");
endmodule // mrz_chk

bind mrz_mode_reg mrz_chk i_chk (.clk_sys_in, .reset_n_in, .cs_n_in, .ras_n_in, .cas_n_in,
    .we_n_in, .bg_in, .ba_in, .addr_in, .mode_register_zero_out, .mrs_target_out,
    .mrs_other_out, .reserved_set_out, .dll_reset_pulse_out, .dll_reset_busy_out);

// [verif/mrz_ctl_model.sv]
// Purpose: Controller model issuing mode register set commands.
// Assumes: Drives at the falling clock edge.
// Notes:   Released address lines show the inverse of their last value.
module mrz_ctl_model (
    input  wire        clk_sys_in,
    output logic       cs_n_out,
    output logic       ras_n_out,
    output logic       cas_n_out,
    output logic       we_n_out,
    output logic [1:0] bg_out,
    output logic [1:0] ba_out,
    output logic [17:0] addr_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // No termination pin is driven, so ODT never rises.
    initial {cs_n_out, ras_n_out, cas_n_out, we_n_out, bg_out, ba_out, addr_out} = 26'h3c0_0000;
    task automatic mrs(input logic [21:0] w);
        @(negedge clk_sys_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'h0;
        {bg_out, ba_out, addr_out} = {w[21:17], 3'h0, w[13:0]};
        @(negedge clk_sys_in);
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
        {bg_out, ba_out, addr_out} = ~{bg_out, ba_out, addr_out};
    endtask
endmodule // mrz_ctl_model
